/* bench/cgen_ref_model.sv */
// Behavioural model of the external reference source and the loop lock
`timescale 1ns/1ps
module cgen_ref_model #(
  parameter logic [15:0] KHZ      = 16'h0020,
  parameter logic [11:0] FILTER_VALUE      = 12'h5A3,
  parameter logic [3:0]  LOCK_DLY = 4'h6
) (
  input  wire logic        pclk,
  input  wire logic        ref_on,
  input  wire logic        lock_on,
  output logic      [15:0] ext_ref_khz,
  output logic             ext_ref_ok,
  output logic             loop_locked,
  output logic      [11:0] loop_filter_in
);
  logic [3:0] lock_cnt_r = 4'h0;
  initial begin
    ext_ref_khz    = 16'h0000;
    ext_ref_ok     = 1'b0;
    loop_locked    = 1'b0;
    loop_filter_in = 12'h000;
  end
  // Without a reference the frequency and filter words are meaningless
  always @(posedge pclk) begin
    ext_ref_ok     <= ref_on;
    ext_ref_khz    <= ref_on ? KHZ : ~ext_ref_khz;
    loop_filter_in <= (ref_on && lock_on) ? FILTER_VALUE : ~loop_filter_in;
  end
  // Lock is declared some cycles after the reference settles
  always @(posedge pclk) begin
    lock_cnt_r  <= !(ref_on && lock_on) ? 4'h0 :
                   (lock_cnt_r == LOCK_DLY) ? lock_cnt_r : lock_cnt_r + 4'h1;
    loop_locked <= (lock_cnt_r == LOCK_DLY);
  end
endmodule : cgen_ref_model

/* bench/cgen_top_chk.sv */
// Port level assertions for the clock generator configuration block
`timescale 1ns/1ps
module cgen_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] output_khz,
  input wire logic [31:0] bus_khz,
  input wire logic [1:0]  mode_status,
  input wire logic        osc_gain_high,
  input wire logic        loss_reset_req,
  input wire logic        loss_irq_req
);
  // ****
  // Helpers
  // ****
  logic       acc;
  logic       wr_ctl1;
  logic       clr_stat;
  logic [1:0] wr_mode;
  logic [1:0] gain_age_r;
  logic       rst_en_r;
  default clocking dck @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed accesses of interest
  assign acc      = psel && penable && pready;
  assign wr_ctl1  = acc && pwrite && paddr == cgen_pkg::CTL1_OFS;
  assign clr_stat = acc && pwrite && paddr == cgen_pkg::STAT1_OFS && pwdata[0];
  assign wr_mode  = pwdata[4:3];
  // Age since the first control one write, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gain_age_r <= 2'h0;
    else if (wr_ctl1 || gain_age_r != 2'h0)
      gain_age_r <= (gain_age_r == 2'h3) ? 2'h3 : gain_age_r + 2'h1;
  end
  // Any loss reset enable of control two as last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rst_en_r <= 1'b0;
    else if (acc && pwrite && paddr == cgen_pkg::CTL2_OFS)
      rst_en_r <= pwdata[cgen_pkg::LOSS_OF_LOCK_RESET_ENABLE_BIT] | pwdata[cgen_pkg::LOSS_OF_CLOCK_RESET_ENABLE_BIT];
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctl1_quiet;
    wr_ctl1 ##1 !wr_ctl1 [*3];
  endsequence
  // ****
  // Assertions
  // ****
  a_ready_single: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_unmapped_err: assert property (psel && !penable |=>
    pslverr == ($past(paddr[1:0]) != 2'h0 || $past(paddr) > cgen_pkg::TRIM_OFS))
    else $error("pslverr does not match address map");
  a_bus_half: assert property ($stable(output_khz) [*2] |-> bus_khz == (output_khz >> 1))
    else $error("bus frequency not half of output");
  a_reset_pulse: assert property (loss_reset_req |=> !loss_reset_req)
    else $error("loss reset request longer than one cycle");
  a_reset_gated: assert property (loss_reset_req |-> $past(rst_en_r))
    else $error("loss reset request with both reset enables clear");
  a_flag_sticky: assert property (loss_irq_req && !clr_stat |=> loss_irq_req)
    else $error("pending flag dropped without clear");
  a_mode_lag: assert property (s_ctl1_quiet |-> ##2 mode_status == $past(wr_mode, 5))
    else $error("mode status did not follow after lag");
  a_ctl1_zero: assert property (acc && !pwrite && paddr == cgen_pkg::CTL1_OFS |->
    prdata[0] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("control one reserved bits not zero");
  a_filt_upper: assert property (acc && !pwrite && paddr == cgen_pkg::FILT_OFS |->
    prdata[31:12] == 20'h0)
    else $error("filter upper bits not zero");
  a_gain_once: assert property (gain_age_r == 2'h3 |-> $stable(osc_gain_high))
    else $error("gain select changed after first write");
endmodule : cgen_top_chk
bind cgen_top cgen_top_chk u_cgen_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .output_khz(output_khz), .bus_khz(bus_khz),
  .mode_status(mode_status), .osc_gain_high(osc_gain_high),
  .loss_reset_req(loss_reset_req), .loss_irq_req(loss_irq_req));

/* bench/cgen_top_test.sv */
// Self-checking bench for the clock generator configuration block
`timescale 1ns/1ps
module cgen_top_test;
  localparam int EXT = 32;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, irg_trim;
  logic [31:0] pwdata, prdata, output_khz, bus_khz, rd;
  logic [15:0] ext_ref_khz;
  logic [11:0] loop_filter_in, filter_out;
  logic [1:0]  mode_status;
  logic        ext_ref_ok, loop_locked, osc_request, osc_gain_high, osc_range_high;
  logic        osc_stop_enable, loss_reset_req, loss_irq_req, ref_on, lock_on, er;
  int          err_total, total_checks, pulses;
  cgen_top u_cgen_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_ref_khz(ext_ref_khz), .ext_ref_ok(ext_ref_ok),
    .loop_locked(loop_locked), .loop_filter_in(loop_filter_in), .output_khz(output_khz),
    .bus_khz(bus_khz), .mode_status(mode_status), .osc_request(osc_request),
    .osc_gain_high(osc_gain_high), .osc_range_high(osc_range_high),
    .osc_stop_enable(osc_stop_enable), .irg_trim(irg_trim), .filter_out(filter_out),
    .loss_reset_req(loss_reset_req), .loss_irq_req(loss_irq_req));
  cgen_ref_model #(.KHZ(16'(EXT))) u_cgen_ref_model (.pclk(pclk), .ref_on(ref_on),
    .lock_on(lock_on), .ext_ref_khz(ext_ref_khz), .ext_ref_ok(ext_ref_ok),
    .loop_locked(loop_locked), .loop_filter_in(loop_filter_in));
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    stop_test();
  end
  // Count loss reset pulses
  always @(posedge pclk) if (loss_reset_req === 1'b1) pulses <= pulses + 1;
  // ****
  // Shared tasks
  // ****
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc
  task automatic do_reset();
    presetn <= 1'b0;
    wait_cyc(4);
    presetn <= 1'b1;
    wait_cyc(1);
  endtask : do_reset
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Access holds until ready is seen at a rising edge; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    chk(output_khz, 8000);
    chk(bus_khz, 4000);
    rdc(cgen_pkg::CTL1_OFS, 32'h0);
    rdc(cgen_pkg::TRIM_OFS, 32'h80);
    wr(cgen_pkg::FILT_OFS, 32'hFFFFFFFF);
    rdc(cgen_pkg::FILT_OFS, 32'hFFF);
    wr(cgen_pkg::TRIM_OFS, 32'h3C);
    wait_cyc(1);
    chk(irg_trim, 8'h3C);
    rdc(8'h40, 32'h0);
    chk(er, 1);
  endtask : t_reset
  task automatic t_fee();
    int f;
    ref_on  <= 1'b1;
    lock_on <= 1'b1;
    wr(cgen_pkg::CTL2_OFS, 32'h00);
    wr(cgen_pkg::CTL1_OFS, 32'h38);
    wait_cyc(2);
    chk(output_khz, EXT * 64 * 4);
    chk(osc_request, 1);
    for (f = 0; f < 8; f++) begin
      wr(cgen_pkg::CTL2_OFS, {25'h0, 3'(f), 1'b0, 3'(f)});
      wait_cyc(2);
      chk(output_khz, (EXT * 64 * (4 + 2 * f)) >> f);
      chk(bus_khz, ((EXT * 64 * (4 + 2 * f)) >> f) / 2);
    end
    wr(cgen_pkg::CTL2_OFS, 32'h30);
    wr(cgen_pkg::CTL1_OFS, 32'h78);
    wait_cyc(2);
    chk(output_khz, EXT * 10);
    chk(osc_range_high, 1);
    chk(filter_out, 12'h5A3);
    rdc(cgen_pkg::FILT_OFS, 32'h5A3);
    wait_cyc(130);
    rdc(cgen_pkg::STAT2_OFS, 32'h1);
    wr(cgen_pkg::STAT2_OFS, 32'h0);
    rdc(cgen_pkg::STAT2_OFS, 32'h1);
  endtask : t_fee
  task automatic t_fei();
    wr(cgen_pkg::CTL2_OFS, 32'h31);
    wr(cgen_pkg::CTL1_OFS, 32'h28);
    chk(mode_status, 2'h3);
    wait_cyc(2);
    chk(output_khz, ((243 * 64 * 10) / 7) >> 1);
    chk(osc_request, 0);
    wait_cyc(4);
    chk(mode_status, 2'h1);
    wr(cgen_pkg::CTL2_OFS, 32'h32);
    wr(cgen_pkg::TRIM_OFS, 32'h41);
    wait_cyc(1);
    chk(output_khz, ((243 * 64 * 10) / 7) >> 2);
    chk(irg_trim, 8'h41);
    wr(cgen_pkg::CTL2_OFS, 32'h31);
    wait_cyc(2);
    chk(output_khz, ((243 * 64 * 10) / 7) >> 1);
  endtask : t_fei
  task automatic t_events();
    int p;
    wr(cgen_pkg::CTL1_OFS, 32'h38);
    wr(cgen_pkg::CTL2_OFS, 32'h00);
    wait_cyc(10);
    wr(cgen_pkg::STAT1_OFS, 32'h01);
    p = pulses;
    ref_on <= 1'b0;
    wait_cyc(6);
    chk(loss_irq_req, 1);
    rdc(cgen_pkg::STAT1_OFS, 32'hD5);
    chk(pulses, p);
    ref_on <= 1'b1;
    wait_cyc(20);
    wr(cgen_pkg::STAT1_OFS, 32'hFF);
    rdc(cgen_pkg::STAT1_OFS, 32'hCA);
    chk(loss_irq_req, 0);
    wr(cgen_pkg::CTL2_OFS, 32'h80);
    lock_on <= 1'b0;
    wait_cyc(6);
    chk(pulses, p + 1);
    lock_on <= 1'b1;
  endtask : t_events
  task automatic t_gain();
    do_reset();
    wr(cgen_pkg::CTL1_OFS, 32'h84);
    wr(cgen_pkg::CTL1_OFS, 32'h00);
    wait_cyc(1);
    chk(osc_gain_high, 1);
    do_reset();
    wr(cgen_pkg::CTL1_OFS, 32'h00);
    wr(cgen_pkg::CTL1_OFS, 32'h84);
    wait_cyc(1);
    chk(osc_gain_high, 0);
    chk(osc_stop_enable, 1);
  endtask : t_gain
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ref_on, lock_on, err_total, total_checks, pulses} = '0;
    do_reset();
    t_reset();
    t_fee();
    t_fei();
    t_events();
    t_gain();
    stop_test();
  end
endmodule : cgen_top_test

/* hw/cgen_freq_calc.sv */
// Output frequency model of the generator from mode, range and divisors
`timescale 1ns/1ps
module cgen_freq_calc #(
  parameter int unsigned EXT_W = 16
) (
  cgen_if.calc            cfg,
  input  wire logic [EXT_W-1:0] ext_khz
);
  logic [31:0] n_val;
  logic [31:0] p_val;
  logic [31:0] base;

  // Loop factors and mode-dependent frequency before reduction
  always_comb begin
    n_val = 32'(cgen_pkg::MFD_BASE) + 32'(cfg.multiplier_field) * 32'(cgen_pkg::MFD_STEP);
    p_val = cfg.range_hi ? 32'(cgen_pkg::P_HIGH) : 32'(cgen_pkg::P_LOW);
    unique case (cfg.mode)
      cgen_pkg::MODE_SCM: base = 32'(cgen_pkg::SCM_KHZ);
      cgen_pkg::MODE_FBE: base = 32'(ext_khz);
      cgen_pkg::MODE_FEI: base = 32'(cgen_pkg::IRG_KHZ) * 32'(cgen_pkg::P_LOW) * n_val
                                 / 32'(cgen_pkg::IRG_DIV);
      cgen_pkg::MODE_FEE: base = 32'(ext_khz) * p_val * n_val;
    endcase
    cfg.out_khz = base >> cfg.reduction_field;
  end
endmodule : cgen_freq_calc

/* hw/cgen_lock_mon.sv */
// Loss-of-lock and loss-of-clock detection and oscillator settle tracking
`timescale 1ns/1ps
module cgen_lock_mon #(
  parameter logic [15:0] SETTLE = 16'(cgen_pkg::SETTLE_CYC)
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ext_ref_ok,
  input  wire logic loop_locked,
  cgen_if.mon       st
);
  logic        lock_q;
  logic        ref_q;
  logic [1:0]  mode_q;
  logic [15:0] cnt_r;
  logic        engaged;
  logic        uses_ext;

  assign engaged  = st.mode[0];
  assign uses_ext = st.ref_req | (st.mode == cgen_pkg::MODE_FEE);

  // Previous levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
      ref_q  <= 1'b0;
      mode_q <= cgen_pkg::MODE_SCM;
    end else begin
      lock_q <= loop_locked;
      ref_q  <= ext_ref_ok;
      mode_q <= st.mode;
    end
  end

  // Settle counter, restarted by a mode change or lost lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
    end else if ((st.mode != mode_q) || (engaged && !loop_locked)) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r != SETTLE) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  assign st.lol_evt = engaged & lock_q & ~loop_locked;
  assign st.loc_evt = uses_ext & ~st.loss_of_clock_disable & ref_q & ~ext_ref_ok;
  assign st.locked  = lock_q;
  assign st.ref_ok  = ref_q;
  assign st.oscillator_stable_status    = (cnt_r == SETTLE);
endmodule : cgen_lock_mon

/* hw/cgen_top.sv */
// Clock generator configuration and status block with an APB register slave
`timescale 1ns/1ps
module cgen_top #(
  parameter int unsigned EXT_W = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [cgen_pkg::AW-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [EXT_W-1:0]         ext_ref_khz,
  input  wire logic                     ext_ref_ok,
  input  wire logic                     loop_locked,
  input  wire logic [11:0]              loop_filter_in,
  output logic      [31:0]              output_khz,
  output logic      [31:0]              bus_khz,
  output logic      [1:0]               mode_status,
  output logic                          osc_request,
  output logic                          osc_gain_high,
  output logic                          osc_range_high,
  output logic                          osc_stop_enable,
  output logic      [7:0]               irg_trim,
  output logic      [11:0]              filter_out,
  output logic                          loss_reset_req,
  output logic                          loss_irq_req
);
  // ****************************************
  // Declarations
  // ****************************************
  cgen_if cfg ();
  logic [7:0]  ctl1_r;
  logic [7:0]  ctl2_r;
  logic        gain_once_r;
  logic        flag_r;
  logic        flag_nxt;
  logic        lols_r;
  logic        locs_r;
  logic [11:0] filt_r;
  logic [7:0]  trim_r;
  logic [1:0]  clock_mode_status_r;
  logic [2:0]  lag_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] out_khz_r;
  logic [31:0] bus_khz_r;
  logic        osc_req_r;
  logic        gain_r;
  logic        range_r;
  logic        stopen_r;
  logic [7:0]  trim_out_r;
  logic [11:0] filt_out_r;
  logic        rst_req_r;
  logic        irq_r;
  logic        setup;
  logic        wr_done;
  logic        hit;
  logic [31:0] rd_mux;
  logic [7:0]  stat1_v;
  logic        wr_ctl1;
  logic        wr_ctl2;
  logic        wr_stat1;
  logic        wr_filt;
  logic        wr_trim;
  logic        clr_flag;
  logic        lol_irq;
  logic        loc_irq;
  logic        lol_rst;
  logic        loc_rst;
  logic        engaged;

  // ****************************************
  // Configuration fanout
  // ****************************************
  // Fields seen by the frequency model and the monitor
  assign cfg.mode     = ctl1_r[cgen_pkg::MODE_LO +: 2];
  assign cfg.range_hi = ctl1_r[cgen_pkg::RANGE_BIT];
  assign cfg.ref_req  = ctl1_r[cgen_pkg::REFERENCE_SELECT_BIT]
                        & (cfg.mode != cgen_pkg::MODE_FEI);
  assign cfg.loss_of_clock_disable     = ctl1_r[cgen_pkg::LOSS_OF_CLOCK_DISABLE_BIT];
  assign cfg.multiplier_field      = ctl2_r[cgen_pkg::MFD_LO +: 3];
  assign cfg.reduction_field      = ctl2_r[cgen_pkg::RFD_LO +: 3];
  assign engaged      = cfg.mode[0];

  cgen_freq_calc #(
    .EXT_W   (EXT_W)
  ) u_calc (
    .cfg     (cfg),
    .ext_khz (ext_ref_khz)
  );

  cgen_lock_mon u_mon (
    .pclk        (pclk),
    .presetn     (presetn),
    .ext_ref_ok  (ext_ref_ok),
    .loop_locked (loop_locked),
    .st          (cfg)
  );

  // ****************************************
  // APB decode
  // ****************************************
  // Setup phase and completing access
  assign setup    = psel & ~penable;
  assign wr_done  = psel & penable & pready_r & pwrite;
  assign wr_ctl1  = wr_done & (paddr == cgen_pkg::CTL1_OFS);
  assign wr_ctl2  = wr_done & (paddr == cgen_pkg::CTL2_OFS);
  assign wr_stat1 = wr_done & (paddr == cgen_pkg::STAT1_OFS);
  assign wr_filt  = wr_done & (paddr == cgen_pkg::FILT_OFS);
  assign wr_trim  = wr_done & (paddr == cgen_pkg::TRIM_OFS);

  // Address hit check
  always_comb begin
    unique case (paddr)
      cgen_pkg::CTL1_OFS,
      cgen_pkg::CTL2_OFS,
      cgen_pkg::STAT1_OFS,
      cgen_pkg::STAT2_OFS,
      cgen_pkg::FILT_OFS,
      cgen_pkg::TRIM_OFS: hit = 1'b1;
      default:            hit = 1'b0;
    endcase
  end

  // Status one image
  always_comb begin
    stat1_v                          = 8'h00;
    stat1_v[cgen_pkg::IF_BIT]        = flag_r;
    stat1_v[cgen_pkg::REFST_BIT]     = cfg.ref_ok;
    stat1_v[cgen_pkg::LOCS_BIT]      = locs_r;
    stat1_v[cgen_pkg::LOCK_BIT]      = cfg.locked;
    stat1_v[cgen_pkg::LOLS_BIT]      = lols_r;
    stat1_v[cgen_pkg::CLOCK_MODE_STATUS_LO +: 2] = clock_mode_status_r;
  end

  // Read data mux, unused upper bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      cgen_pkg::CTL1_OFS:  rd_mux[7:0] = ctl1_r;
      cgen_pkg::CTL2_OFS:  rd_mux[7:0] = ctl2_r;
      cgen_pkg::STAT1_OFS: rd_mux[7:0] = stat1_v;
      cgen_pkg::STAT2_OFS: rd_mux[cgen_pkg::OSCILLATOR_STABLE_STATUS_BIT] = cfg.oscillator_stable_status;
      cgen_pkg::FILT_OFS:  rd_mux[cgen_pkg::FILT_W-1:0] = filt_r;
      cgen_pkg::TRIM_OFS:  rd_mux[7:0] = trim_r;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // No wait states: ready and data prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit;
      if (setup) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Control one, bit 0 held at zero, gain taken once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_r      <= cgen_pkg::CTL1_RST;
      gain_once_r <= 1'b0;
    end else if (wr_ctl1) begin
      ctl1_r[7:1] <= {ctl1_r[cgen_pkg::GAIN_BIT], pwdata[6:1]};
      ctl1_r[0]   <= 1'b0;
      gain_once_r <= 1'b1;
      if (!gain_once_r) begin
        ctl1_r[cgen_pkg::GAIN_BIT] <= pwdata[cgen_pkg::GAIN_BIT];
      end
    end
  end

  // Control two, plain read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl2_r <= cgen_pkg::CTL2_RST;
    end else if (wr_ctl2) begin
      ctl2_r <= pwdata[7:0];
    end
  end

  // Trim register, kept for the internal reference only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_r <= cgen_pkg::TRIM_RST;
    end else if (wr_trim) begin
      trim_r <= pwdata[7:0];
    end
  end

  // Filter: loop owns it when engaged, software otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_r <= cgen_pkg::FILT_RST;
    end else if (engaged) begin
      filt_r <= loop_filter_in;
    end else if (wr_filt) begin
      filt_r <= pwdata[cgen_pkg::FILT_W-1:0];
    end
  end

  // ****************************************
  // Mode status lag
  // ****************************************
  // Status follows the select after a few cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lag_r   <= 3'h0;
      clock_mode_status_r <= cgen_pkg::MODE_SCM;
    end else begin
      if (wr_ctl1) begin
        lag_r <= cgen_pkg::CLOCK_MODE_STATUS_LAG;
      end else if (lag_r != 3'h0) begin
        lag_r <= lag_r - 3'h1;
      end
      if (lag_r == 3'h1) begin
        clock_mode_status_r <= cfg.mode;
      end
    end
  end

  // ****************************************
  // Loss events
  // ****************************************
  // Route each event to reset or interrupt
  assign lol_rst  = cfg.lol_evt & ctl2_r[cgen_pkg::LOSS_OF_LOCK_RESET_ENABLE_BIT];
  assign lol_irq  = cfg.lol_evt & ~ctl2_r[cgen_pkg::LOSS_OF_LOCK_RESET_ENABLE_BIT];
  assign loc_rst  = cfg.loc_evt & ctl2_r[cgen_pkg::LOSS_OF_CLOCK_RESET_ENABLE_BIT];
  assign loc_irq  = cfg.loc_evt & ~ctl2_r[cgen_pkg::LOSS_OF_CLOCK_RESET_ENABLE_BIT];
  assign clr_flag = wr_stat1 & pwdata[cgen_pkg::IF_BIT];
  // Set wins over a clear in the same cycle
  assign flag_nxt = (flag_r & ~clr_flag) | lol_irq | loc_irq;

  // Pending flag and per-cause status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
      lols_r <= 1'b0;
      locs_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      lols_r <= (lols_r & ~clr_flag) | cfg.lol_evt;
      locs_r <= (locs_r & ~clr_flag) | cfg.loc_evt;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Frequency figures, self-clocked values at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_khz_r <= 32'(cgen_pkg::SCM_KHZ);
      bus_khz_r <= 32'(cgen_pkg::SCM_KHZ) >> cgen_pkg::BUS_SHIFT;
    end else begin
      out_khz_r <= cfg.out_khz;
      bus_khz_r <= cfg.out_khz >> cgen_pkg::BUS_SHIFT;
    end
  end

  // Oscillator controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_req_r  <= 1'b0;
      gain_r     <= 1'b0;
      range_r    <= 1'b0;
      stopen_r   <= 1'b0;
      trim_out_r <= cgen_pkg::TRIM_RST;
      filt_out_r <= cgen_pkg::FILT_RST;
    end else begin
      osc_req_r  <= cfg.ref_req;
      gain_r     <= ctl1_r[cgen_pkg::GAIN_BIT];
      range_r    <= cfg.range_hi;
      stopen_r   <= ctl1_r[cgen_pkg::STOPEN_BIT];
      trim_out_r <= trim_r;
      filt_out_r <= filt_r;
    end
  end

  // Reset request pulse and interrupt level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_req_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      rst_req_r <= lol_rst | loc_rst;
      irq_r     <= flag_nxt;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign output_khz      = out_khz_r;
  assign bus_khz         = bus_khz_r;
  assign mode_status     = clock_mode_status_r;
  assign osc_request     = osc_req_r;
  assign osc_gain_high   = gain_r;
  assign osc_range_high  = range_r;
  assign osc_stop_enable = stopen_r;
  assign irg_trim        = trim_out_r;
  assign filter_out      = filt_out_r;
  assign loss_reset_req  = rst_req_r;
  assign loss_irq_req    = irq_r;
endmodule : cgen_top

/* inc/cgen_if.sv */
// Configuration and status carrier between the generator control and its helpers
`timescale 1ns/1ps
interface cgen_if;
  logic [1:0]  mode;
  logic        range_hi;
  logic        ref_req;
  logic        loss_of_clock_disable;
  logic [2:0]  multiplier_field;
  logic [2:0]  reduction_field;
  logic [31:0] out_khz;
  logic        lol_evt;
  logic        loc_evt;
  logic        locked;
  logic        ref_ok;
  logic        oscillator_stable_status;
  modport ctl  (output mode, range_hi, ref_req, loss_of_clock_disable, multiplier_field, reduction_field,
                input  out_khz, lol_evt, loc_evt, locked, ref_ok, oscillator_stable_status);
  modport calc (input  mode, range_hi, multiplier_field, reduction_field, output out_khz);
  modport mon  (input  mode, ref_req, loss_of_clock_disable,
                output lol_evt, loc_evt, locked, ref_ok, oscillator_stable_status);
endinterface : cgen_if

/* inc/cgen_pkg.sv */
// Constants and types for the clock generator configuration block
package cgen_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int unsigned  AW         = 8;
  localparam logic [7:0]   CTL1_OFS   = 8'h00;
  localparam logic [7:0]   CTL2_OFS   = 8'h04;
  localparam logic [7:0]   STAT1_OFS  = 8'h08;
  localparam logic [7:0]   STAT2_OFS  = 8'h0C;
  localparam logic [7:0]   FILT_OFS   = 8'h10;
  localparam logic [7:0]   TRIM_OFS   = 8'h14;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned  GAIN_BIT   = 7;
  localparam int unsigned  RANGE_BIT  = 6;
  localparam int unsigned  REFERENCE_SELECT_BIT   = 5;
  localparam int unsigned  MODE_LO    = 3;
  localparam int unsigned  STOPEN_BIT = 2;
  localparam int unsigned  LOSS_OF_CLOCK_DISABLE_BIT   = 1;
  localparam int unsigned  LOSS_OF_LOCK_RESET_ENABLE_BIT  = 7;
  localparam int unsigned  MFD_LO     = 4;
  localparam int unsigned  LOSS_OF_CLOCK_RESET_ENABLE_BIT  = 3;
  localparam int unsigned  RFD_LO     = 0;
  localparam int unsigned  IF_BIT     = 0;
  localparam int unsigned  REFST_BIT  = 1;
  localparam int unsigned  LOCS_BIT   = 2;
  localparam int unsigned  LOCK_BIT   = 3;
  localparam int unsigned  LOLS_BIT   = 4;
  localparam int unsigned  CLOCK_MODE_STATUS_LO   = 6;
  localparam int unsigned  OSCILLATOR_STABLE_STATUS_BIT   = 0;
  localparam int unsigned  FILT_W     = 12;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]   CTL1_RST   = 8'h00;
  localparam logic [7:0]   CTL2_RST   = 8'h00;
  localparam logic [11:0]  FILT_RST   = 12'h800;
  localparam logic [7:0]   TRIM_RST   = 8'h80;
  // ****************************************
  // Clock modes and frequency figures
  // ****************************************
  typedef logic [1:0] cgen_mode_t;
  localparam cgen_mode_t   MODE_SCM   = 2'b00;
  localparam cgen_mode_t   MODE_FEI   = 2'b01;
  localparam cgen_mode_t   MODE_FBE   = 2'b10;
  localparam cgen_mode_t   MODE_FEE   = 2'b11;
  localparam int unsigned  SCM_KHZ    = 8000;
  localparam int unsigned  IRG_KHZ    = 243;
  localparam int unsigned  IRG_DIV    = 7;
  localparam int unsigned  P_LOW      = 64;
  localparam int unsigned  P_HIGH     = 1;
  localparam int unsigned  MFD_BASE   = 4;
  localparam int unsigned  MFD_STEP   = 2;
  localparam int unsigned  BUS_SHIFT  = 1;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned  PCLK_KHZ   = 125000;
  localparam int unsigned  SETTLE_NS  = 1000;
  localparam int unsigned  SETTLE_CYC = (SETTLE_NS * (PCLK_KHZ / 1000) + 999) / 1000;
  localparam logic [2:0]   CLOCK_MODE_STATUS_LAG  = 3'h4;
endpackage : cgen_pkg
